// File: crtv_hsrc.sv
`timescale 1ns/1ps
// Horizontal timing source: one retrace pulse every four cycles, hsync after it
module crtv_hsrc (
  input wire logic i_clk,
  input wire logic i_run,
  output logic o_hretrace,
  output logic o_hsync,
  output logic o_char_en
);
  logic [1:0] cnt = 2'h0;
  initial {o_hretrace, o_hsync, o_char_en} = 3'h0;
  // Stands still between runs so no line advances while registers change
  always @(negedge i_clk) begin
    if (!i_run) begin
      cnt <= 2'h0;
      {o_hretrace, o_hsync, o_char_en} <= 3'h0;
    end else begin
      cnt <= cnt + 2'h1;
      o_hretrace <= (cnt == 2'h0);
      o_hsync <= (cnt == 2'h1) || (cnt == 2'h2);
      o_char_en <= cnt[0];
    end
  end
endmodule

// File: crtv_pkg.sv
package crtv_pkg;

  // Register indexes
  localparam logic [7:0] IDX_VERT_TOTAL_LOW = 8'h06;
  localparam logic [7:0] IDX_OVERFLOW = 8'h07;
  localparam logic [7:0] IDX_MAX_SCAN_LINE = 8'h09;
  localparam logic [7:0] IDX_VSYNC_START_LOW = 8'h10;
  localparam logic [7:0] IDX_VSYNC_END_IRQ = 8'h11;
  localparam logic [7:0] IDX_DISPLAY_END_LOW = 8'h12;
  localparam logic [7:0] IDX_ROW_PITCH_LOW = 8'h13;
  localparam logic [7:0] IDX_UNDERLINE_DWORD = 8'h14;
  localparam logic [7:0] IDX_VBLANK_START_LOW = 8'h15;
  localparam logic [7:0] IDX_VBLANK_END = 8'h16;
  localparam logic [7:0] IDX_CRTC_MODE = 8'h17;
  localparam logic [7:0] IDX_FORCE_DWORD = 8'h31;
  localparam logic [7:0] IDX_GLOBAL_IRQ_EN = 8'h32;
  localparam logic [7:0] IDX_REFRESH_OVERRIDE = 8'h3A;
  localparam logic [7:0] IDX_PITCH_EXT = 8'h51;
  localparam logic [7:0] IDX_VERT_EXT = 8'h5E;
  // Highest index covered by the timing write lock
  localparam logic [7:0] IDX_LOCK_LAST = 8'h07;

  // Field positions
  localparam int OVF_VT8 = 0;
  localparam int OVF_VDE8 = 1;
  localparam int OVF_VRS8 = 2;
  localparam int OVF_SVB8 = 3;
  localparam int OVF_LINE_COMPARE_BIT8 = 4;
  localparam int OVF_VT9 = 5;
  localparam int OVF_VDE9 = 6;
  localparam int OVF_VRS9 = 7;
  localparam int MSL_SVB9 = 5;
  localparam int VRE_CLEAR_N = 4;
  localparam int VRE_DISABLE = 5;
  localparam int VRE_REFRESH5 = 6;
  localparam int VRE_LOCK = 7;
  localparam int ULD_COUNT4 = 5;
  localparam int ULD_DWORD = 6;
  localparam int MD_BANK2_N = 0;
  localparam int MD_BANK4_N = 1;
  localparam int MD_VHALVE = 2;
  localparam int MD_WORD_SEL = 3;
  localparam int MD_WRAP = 5;
  localparam int MD_BYTE = 6;
  localparam int MD_RETRACE_EN = 7;
  localparam int FD_FORCE_DWORD = 3;
  localparam int GI_IRQ_EN = 4;
  localparam int EXT_VT10 = 0;
  localparam int EXT_VDE10 = 1;
  localparam int EXT_SVB10 = 2;
  localparam int EXT_VRS10 = 4;
  localparam int PX_PITCH_LO = 4;

  // Reset values
  localparam logic [7:0] RST_VSYNC_END_IRQ = 8'h80;
  localparam logic [7:0] RST_CRTC_MODE = 8'h00;
  localparam logic [7:0] RST_OTHER = 8'h00;

  // Refresh cycles per line
  localparam logic [2:0] REFRESH_THREE = 3'h3;
  localparam logic [2:0] REFRESH_FIVE = 3'h5;
  localparam logic [2:0] REFRESH_OVR1 = 3'h1;
  localparam logic [2:0] REFRESH_OVR2 = 3'h2;
  localparam logic [2:0] REFRESH_OVR3 = 3'h4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } crtv_host_t;

  typedef enum logic [1:0] {
    CRTV_PITCH_WORD,
    CRTV_PITCH_DWORD,
    CRTV_PITCH_QWORD
  } crtv_pitch_t;

endpackage

// File: crtv_vtiming.sv
`timescale 1ns/1ps
// Summary of operation
// (RULE1) Sync ends when scan line low four bits match the sync-end field.
// (RULE2) Flip-flop sets at end of active display; output drives interrupt line.
// (RULE3) Clear bit at 0 clears and holds flip-flop clear; 1 re-arms it.
// (RULE4) Disable bit 1 blocks interrupt; at 0 the global enable must be set.
// (RULE5) Three or five refresh cycles per line, or as override field picks.
// (RULE6) Lock bit blocks writes to indexes 0-7 except line-compare bit 8.
// (RULE7) Display end is 11-bit active lines minus one, split over three registers.
// (RULE8) Row start advances by pitch times 2, 4 or 8.
// (RULE9) Extended force bit selects doubleword pitch regardless of mode bits.
// (RULE10) Underline drawn on row scan equal to field plus one.
// (RULE11) Count-by-four bit makes address counter step every four character clocks.
// (RULE12) Doubleword bit selects doubleword memory addresses.
// (RULE13) Vertical blank starts at 11-bit start value plus one.
// (RULE14) Blank ends when scan line low eight bits match blank-end field.
// (RULE15) Bank-2 bit 0 puts row scan bit 0 on address bit 13.
// (RULE16) Bank-4 bit 0 puts row scan bit 1 on address bit 14.
// (RULE17) Vertical counter steps on every or every second horizontal retrace.
// (RULE18) Word-select bit halves address counter rate and, with doubleword, picks quadword pitch.
// (RULE19) Word mode puts counter bit 13 or 15 on address bit 0.
// (RULE20) Byte-mode bit 0 rotates counter up one, top bit to bit 0; code puts bit 13 there instead unless the wrap bit is set.
// (RULE21) Retrace-enable bit 0 holds both retrace pulses inactive.
// (RULE22) Scan line counter returns to zero after total plus two lines.
// (RULE23) Vertical sync starts when scan line equals 11-bit retrace start.
// (RULE24) Partial end compares are only armed after the matching start.
module crtv_vtiming
  import crtv_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire crtv_host_t i_host,
  input wire logic i_char_clk_en,
  input wire logic i_hretrace,
  input wire logic i_hsync,
  input wire logic [15:0] i_start_addr,
  output logic [7:0] o_rdata,
  output logic o_vsync,
  output logic o_hsync,
  output logic o_vblank,
  output logic o_display_en,
  output logic o_vert_irq,
  output logic o_underline,
  output logic [15:0] o_mem_addr,
  output logic [4:0] o_row_scan,
  output logic [2:0] o_refresh_cycles
);

  // Register file
  logic [7:0] vt_low_r, vt_low_nxt;
  logic [7:0] ovf_r, ovf_nxt;
  logic [7:0] msl_r, msl_nxt;
  logic [7:0] vrs_low_r, vrs_low_nxt;
  logic [7:0] vre_r, vre_nxt;
  logic [7:0] vde_low_r, vde_low_nxt;
  logic [7:0] pitch_low_r, pitch_low_nxt;
  logic [7:0] uld_r, uld_nxt;
  logic [7:0] svb_low_r, svb_low_nxt;
  logic [7:0] evb_r, evb_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] fdw_r, fdw_nxt;
  logic [7:0] gie_r, gie_nxt;
  logic [7:0] rov_r, rov_nxt;
  logic [7:0] pext_r, pext_nxt;
  logic [7:0] vext_r, vext_nxt;
  logic [7:0] rdata_nxt;

  function automatic logic [7:0] reg_merge(input logic [7:0] cur,
                                           input logic [7:0] idx,
                                           input crtv_host_t h);
    reg_merge = (h.wr && h.index == idx) ? h.wdata : cur;
  endfunction

  always_comb begin
    logic locked;
    locked = vre_r[VRE_LOCK] && i_host.index <= IDX_LOCK_LAST; // RULE6
    vt_low_nxt = locked ? vt_low_r : reg_merge(vt_low_r, IDX_VERT_TOTAL_LOW, i_host);
    ovf_nxt = reg_merge(ovf_r, IDX_OVERFLOW, i_host);
    if (locked) begin
      ovf_nxt = ovf_r;
      ovf_nxt[OVF_LINE_COMPARE_BIT8] = (i_host.wr && i_host.index == IDX_OVERFLOW) ?
                          i_host.wdata[OVF_LINE_COMPARE_BIT8] : ovf_r[OVF_LINE_COMPARE_BIT8]; // RULE6
    end
    msl_nxt = reg_merge(msl_r, IDX_MAX_SCAN_LINE, i_host);
    vrs_low_nxt = reg_merge(vrs_low_r, IDX_VSYNC_START_LOW, i_host);
    vre_nxt = reg_merge(vre_r, IDX_VSYNC_END_IRQ, i_host);
    vde_low_nxt = reg_merge(vde_low_r, IDX_DISPLAY_END_LOW, i_host);
    pitch_low_nxt = reg_merge(pitch_low_r, IDX_ROW_PITCH_LOW, i_host);
    uld_nxt = reg_merge(uld_r, IDX_UNDERLINE_DWORD, i_host);
    uld_nxt[7] = 1'b0;
    svb_low_nxt = reg_merge(svb_low_r, IDX_VBLANK_START_LOW, i_host);
    evb_nxt = reg_merge(evb_r, IDX_VBLANK_END, i_host);
    mode_nxt = reg_merge(mode_r, IDX_CRTC_MODE, i_host);
    mode_nxt[4] = 1'b0;
    fdw_nxt = reg_merge(fdw_r, IDX_FORCE_DWORD, i_host);
    gie_nxt = reg_merge(gie_r, IDX_GLOBAL_IRQ_EN, i_host);
    rov_nxt = reg_merge(rov_r, IDX_REFRESH_OVERRIDE, i_host);
    pext_nxt = reg_merge(pext_r, IDX_PITCH_EXT, i_host);
    vext_nxt = reg_merge(vext_r, IDX_VERT_EXT, i_host);
    rdata_nxt = o_rdata;
    if (i_host.rd) begin
      case (i_host.index)
        IDX_VERT_TOTAL_LOW: rdata_nxt = vt_low_r;
        IDX_OVERFLOW: rdata_nxt = ovf_r;
        IDX_MAX_SCAN_LINE: rdata_nxt = msl_r;
        IDX_VSYNC_START_LOW: rdata_nxt = vrs_low_r;
        IDX_VSYNC_END_IRQ: rdata_nxt = vre_r;
        IDX_DISPLAY_END_LOW: rdata_nxt = vde_low_r;
        IDX_ROW_PITCH_LOW: rdata_nxt = pitch_low_r;
        IDX_UNDERLINE_DWORD: rdata_nxt = uld_r;
        IDX_VBLANK_START_LOW: rdata_nxt = svb_low_r;
        IDX_VBLANK_END: rdata_nxt = evb_r;
        IDX_CRTC_MODE: rdata_nxt = mode_r;
        IDX_FORCE_DWORD: rdata_nxt = fdw_r;
        IDX_GLOBAL_IRQ_EN: rdata_nxt = gie_r;
        IDX_REFRESH_OVERRIDE: rdata_nxt = rov_r;
        IDX_PITCH_EXT: rdata_nxt = pext_r;
        IDX_VERT_EXT: rdata_nxt = vext_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vt_low_r <= RST_OTHER;
      ovf_r <= RST_OTHER;
      msl_r <= RST_OTHER;
      vrs_low_r <= RST_OTHER;
      vre_r <= RST_VSYNC_END_IRQ;
      vde_low_r <= RST_OTHER;
      pitch_low_r <= RST_OTHER;
      uld_r <= RST_OTHER;
      svb_low_r <= RST_OTHER;
      evb_r <= RST_OTHER;
      mode_r <= RST_CRTC_MODE;
      fdw_r <= RST_OTHER;
      gie_r <= RST_OTHER;
      rov_r <= RST_OTHER;
      pext_r <= RST_OTHER;
      vext_r <= RST_OTHER;
      o_rdata <= RST_OTHER;
    end else begin
      vt_low_r <= vt_low_nxt;
      ovf_r <= ovf_nxt;
      msl_r <= msl_nxt;
      vrs_low_r <= vrs_low_nxt;
      vre_r <= vre_nxt;
      vde_low_r <= vde_low_nxt;
      pitch_low_r <= pitch_low_nxt;
      uld_r <= uld_nxt;
      svb_low_r <= svb_low_nxt;
      evb_r <= evb_nxt;
      mode_r <= mode_nxt;
      fdw_r <= fdw_nxt;
      gie_r <= gie_nxt;
      rov_r <= rov_nxt;
      pext_r <= pext_nxt;
      vext_r <= vext_nxt;
      o_rdata <= rdata_nxt;
    end
  end

  // Assembled 11-bit vertical values
  logic [10:0] vtotal, display_end_line_low, vrs, vblank_start_low;
  logic [9:0] pitch;
  crtv_pitch_t pitch_mode;
  logic [15:0] pitch_step;

  assign vtotal = {vext_r[EXT_VT10], ovf_r[OVF_VT9], ovf_r[OVF_VT8], vt_low_r};
  assign display_end_line_low = {vext_r[EXT_VDE10], ovf_r[OVF_VDE9], ovf_r[OVF_VDE8], vde_low_r}; // RULE7
  assign vrs = {vext_r[EXT_VRS10], ovf_r[OVF_VRS9], ovf_r[OVF_VRS8], vrs_low_r};
  assign vblank_start_low = {vext_r[EXT_SVB10], msl_r[MSL_SVB9], ovf_r[OVF_SVB8], svb_low_r}; // RULE13
  assign pitch = {pext_r[PX_PITCH_LO+1 -: 2], pitch_low_r}; // RULE8

  always_comb begin
    if (fdw_r[FD_FORCE_DWORD]) begin
      pitch_mode = CRTV_PITCH_DWORD; // RULE9
    end else if (uld_r[ULD_DWORD] && mode_r[MD_WORD_SEL]) begin
      pitch_mode = CRTV_PITCH_QWORD;
    end else if (uld_r[ULD_DWORD]) begin
      pitch_mode = CRTV_PITCH_DWORD;
    end else begin
      pitch_mode = CRTV_PITCH_WORD;
    end
    case (pitch_mode)
      CRTV_PITCH_WORD: pitch_step = {5'h00, pitch, 1'b0}; // RULE8
      CRTV_PITCH_DWORD: pitch_step = {4'h0, pitch, 2'h0};
      CRTV_PITCH_QWORD: pitch_step = {3'h0, pitch, 3'h0};
      default: pitch_step = {5'h00, pitch, 1'b0};
    endcase
  end

  // Vertical and row state
  logic [10:0] vline_r, vline_nxt;
  logic half_r, half_nxt;
  logic [4:0] row_r, row_nxt;
  logic [15:0] row_start_r, row_start_nxt;
  logic [15:0] mac_r, mac_nxt;
  logic [1:0] div_r, div_nxt;
  logic vsync_r, vsync_nxt;
  logic vblank_r, vblank_nxt;
  logic disp_r, disp_nxt;
  logic irq_ff_r, irq_ff_nxt;
  logic hsync_nxt, irq_nxt, ul_nxt;
  logic [15:0] addr_nxt;
  logic [2:0] refresh_nxt;
  logic vstep;

  always_comb begin
    logic [1:0] last_div;
    logic [15:0] shaped;
    last_div = 2'h0;
    shaped = 16'h0000;
    half_nxt = half_r;
    vstep = 1'b0;
    if (i_hretrace) begin
      half_nxt = mode_r[MD_VHALVE] ? ~half_r : 1'b0; // RULE17
      vstep = !mode_r[MD_VHALVE] || half_r;
    end
    vline_nxt = vline_r;
    row_nxt = row_r;
    row_start_nxt = row_start_r;
    vsync_nxt = vsync_r;
    vblank_nxt = vblank_r;
    disp_nxt = disp_r;
    irq_ff_nxt = irq_ff_r;
    if (vstep) begin
      if (vline_r == vtotal + 11'h001) begin
        vline_nxt = 11'h000; // RULE22
        row_nxt = 5'h00;
        row_start_nxt = i_start_addr;
        disp_nxt = 1'b1;
      end else begin
        vline_nxt = vline_r + 11'h001;
        if (row_r == msl_r[4:0]) begin
          row_nxt = 5'h00;
          row_start_nxt = row_start_r + pitch_step; // RULE8
        end else begin
          row_nxt = row_r + 5'h01;
        end
      end
      if (vline_nxt == vrs) begin
        vsync_nxt = 1'b1; // RULE23
      end else if (vsync_r && vline_nxt[3:0] == vre_r[3:0]) begin
        vsync_nxt = 1'b0; // RULE1 RULE24
      end
      if (vline_nxt == vblank_start_low + 11'h001) begin
        vblank_nxt = 1'b1; // RULE13
      end else if (vblank_r && vline_nxt[7:0] == evb_r) begin
        vblank_nxt = 1'b0; // RULE14 RULE24
      end
      if (vline_nxt == display_end_line_low + 11'h001) begin
        disp_nxt = 1'b0; // RULE7
        irq_ff_nxt = 1'b1; // RULE2
      end
    end
    // Clear bit low dominates so the host sees it held clear
    if (!vre_r[VRE_CLEAR_N]) begin
      irq_ff_nxt = 1'b0; // RULE3
    end
    irq_nxt = irq_ff_r && !vre_r[VRE_DISABLE] && gie_r[GI_IRQ_EN]; // RULE4
    // Address counter rate
    if (uld_r[ULD_COUNT4]) begin
      last_div = 2'h3; // RULE11
    end else if (mode_r[MD_WORD_SEL]) begin
      last_div = 2'h1; // RULE18
    end else begin
      last_div = 2'h0;
    end
    mac_nxt = mac_r;
    div_nxt = div_r;
    if (i_hretrace) begin
      mac_nxt = row_start_nxt;
      div_nxt = 2'h0;
    end else if (i_char_clk_en && disp_r) begin
      if (div_r >= last_div) begin
        div_nxt = 2'h0;
        mac_nxt = mac_r + 16'h0001;
      end else begin
        div_nxt = div_r + 2'h1;
      end
    end
    // Address shaping
    if (uld_r[ULD_DWORD]) begin
      shaped = {mac_r[13:0], mac_r[15:14]}; // RULE12
    end else if (!mode_r[MD_BYTE]) begin
      shaped = {mac_r[14:0], mode_r[MD_WRAP] ? mac_r[15] : mac_r[13]}; // RULE19 RULE20
    end else begin
      shaped = mac_r; // RULE20
    end
    addr_nxt = shaped;
    if (disp_r && !mode_r[MD_BANK2_N]) begin
      addr_nxt[13] = row_r[0]; // RULE15
    end
    if (disp_r && !mode_r[MD_BANK4_N]) begin
      addr_nxt[14] = row_r[1]; // RULE16
    end
    ul_nxt = row_r == uld_r[4:0] + 5'h01; // RULE10
    hsync_nxt = i_hsync && mode_r[MD_RETRACE_EN]; // RULE21
    case (rov_r[1:0])
      2'h1: refresh_nxt = REFRESH_OVR1;
      2'h2: refresh_nxt = REFRESH_OVR2;
      2'h3: refresh_nxt = REFRESH_OVR3;
      default: refresh_nxt = vre_r[VRE_REFRESH5] ? REFRESH_FIVE : REFRESH_THREE; // RULE5
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vline_r <= 11'h000;
      half_r <= 1'b0;
      row_r <= 5'h00;
      row_start_r <= 16'h0000;
      mac_r <= 16'h0000;
      div_r <= 2'h0;
      vsync_r <= 1'b0;
      vblank_r <= 1'b0;
      disp_r <= 1'b1;
      irq_ff_r <= 1'b0;
      o_vsync <= 1'b0;
      o_hsync <= 1'b0;
      o_vblank <= 1'b0;
      o_display_en <= 1'b0;
      o_vert_irq <= 1'b0;
      o_underline <= 1'b0;
      o_mem_addr <= 16'h0000;
      o_row_scan <= 5'h00;
      o_refresh_cycles <= REFRESH_THREE;
    end else begin
      vline_r <= vline_nxt;
      half_r <= half_nxt;
      row_r <= row_nxt;
      row_start_r <= row_start_nxt;
      mac_r <= mac_nxt;
      div_r <= div_nxt;
      vsync_r <= vsync_nxt;
      vblank_r <= vblank_nxt;
      disp_r <= disp_nxt;
      irq_ff_r <= irq_ff_nxt;
      o_vsync <= vsync_r && mode_r[MD_RETRACE_EN]; // RULE21
      o_hsync <= hsync_nxt;
      o_vblank <= vblank_r;
      o_display_en <= disp_r;
      o_vert_irq <= irq_nxt;
      o_underline <= ul_nxt;
      o_mem_addr <= addr_nxt;
      o_row_scan <= row_r;
      o_refresh_cycles <= refresh_nxt;
    end
  end

endmodule

// File: crtv_vtiming_props.sv
`timescale 1ns/1ps
module crtv_vtiming_props
  import crtv_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire crtv_host_t i_host,
  input wire logic i_hretrace,
  input wire logic o_vsync,
  input wire logic o_hsync,
  input wire logic o_vblank,
  input wire logic o_display_en,
  input wire logic o_vert_irq,
  input wire logic [2:0] o_refresh_cycles
);
  logic ren_r, ref5_r, dis_r, clr_r, gen_r;
  logic [1:0] ovr_r;
  logic [2:0] ref_exp;
  // Shadows of the few control bits that none of the lock indexes cover
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      {ren_r, ref5_r, dis_r, clr_r, gen_r, ovr_r} <= '0;
    end else if (i_host.wr) begin
      if (i_host.index == IDX_CRTC_MODE) ren_r <= i_host.wdata[MD_RETRACE_EN];
      if (i_host.index == IDX_VSYNC_END_IRQ) begin
        {ref5_r, dis_r, clr_r} <= i_host.wdata[6:4];
      end
      if (i_host.index == IDX_GLOBAL_IRQ_EN) gen_r <= i_host.wdata[GI_IRQ_EN];
      if (i_host.index == IDX_REFRESH_OVERRIDE) ovr_r <= i_host.wdata[1:0];
    end
  end
  always_comb begin
    case (ovr_r)
      2'h1: ref_exp = 3'h1;
      2'h2: ref_exp = 3'h2;
      2'h3: ref_exp = 3'h4;
      default: ref_exp = ref5_r ? 3'h5 : 3'h3;
    endcase
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  ren_off_a: assert property (!ren_r && !$past(ren_r) |-> !o_vsync && !o_hsync)
    else $error("retrace pulse while retrace disabled");
  refresh_sel_a: assert property (ref_exp == $past(ref_exp) && ref_exp == $past(ref_exp, 2)
    |-> o_refresh_cycles == ref_exp) else $error("refresh count wrong");
  irq_disable_a: assert property (dis_r && $past(dis_r) && $past(dis_r, 2) |-> !o_vert_irq)
    else $error("interrupt while disabled");
  irq_clear_a: assert property (!clr_r && !$past(clr_r) && !$past(clr_r, 2) |-> !o_vert_irq)
    else $error("interrupt while held clear");
  irq_global_a: assert property (!gen_r && !$past(gen_r) && !$past(gen_r, 2) |-> !o_vert_irq)
    else $error("interrupt without global enable");
  vblank_step_a: assert property ($changed(o_vblank) |-> $past(i_hretrace, 2))
    else $error("blank moved off a line step");
  vsync_step_a: assert property ($rose(o_vsync) && $past(ren_r, 2) && $past(ren_r, 3)
    |-> $past(i_hretrace, 2)) else $error("sync rose off a line step");
  display_fall_a: assert property ($fell(o_display_en) |-> $past(i_hretrace, 2))
    else $error("display end off a line step");
endmodule
bind crtv_vtiming crtv_vtiming_props u_props (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_host(i_host), .i_hretrace(i_hretrace), .o_vsync(o_vsync), .o_hsync(o_hsync),
  .o_vblank(o_vblank), .o_display_en(o_display_en), .o_vert_irq(o_vert_irq),
  .o_refresh_cycles(o_refresh_cycles));

// File: crtv_vtiming_tb_top.sv
`timescale 1ns/1ps
module crtv_vtiming_tb_top;
  import crtv_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic run = 1'b0;
  crtv_host_t host = '0;
  logic hret, hs, ce, vs, ohs, vb, de, irq;
  logic [7:0] rdata;
  logic [2:0] refc;
  logic ul;
  logic [4:0] rscan;
  logic [15:0] maddr;
  logic [15:0] sa = 16'h0000;
  int n_mismatch = 0;
  int checked = 0;
  int c_vs, c_vb, c_de, c_hs;
  always #2 clk = ~clk;
  crtv_hsrc u_hsrc (.i_clk(clk), .i_run(run), .o_hretrace(hret), .o_hsync(hs), .o_char_en(ce));
  crtv_vtiming u_dut (.i_core_clk(clk), .i_resetn(rstn), .i_host(host), .i_char_clk_en(ce),
    .i_hretrace(hret), .i_hsync(hs), .i_start_addr(sa), .o_rdata(rdata), .o_vsync(vs),
    .o_hsync(ohs), .o_vblank(vb), .o_display_en(de), .o_vert_irq(irq), .o_underline(ul),
    .o_mem_addr(maddr), .o_row_scan(rscan), .o_refresh_cycles(refc));
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clk);
    host = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: d};
    @(negedge clk);
    host = '0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge clk);
    host = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
    @(negedge clk);
    host = '0;
    @(negedge clk);
    cmp("read data", exp, rdata);
  endtask
  task automatic wait_irq(input logic exp);
    repeat (3) @(negedge clk);
    cmp("interrupt", {7'h00, exp}, {7'h00, irq});
  endtask
  // Samples each line's state during the pulse that leaves it, just before the step
  task automatic lines(input int n);
    int k;
    k = 0;
    c_vs = 0;
    c_vb = 0;
    c_de = 0;
    c_hs = 0;
    @(negedge clk);
    #1 run = 1'b1;
    for (int g = 0; g < 8 * n && k < n; g++) begin
      @(negedge clk);
      #1;
      c_hs += (ohs === 1'b1);
      if (hret === 1'b1) begin
        k++;
        c_vs += (vs === 1'b1);
        c_vb += (vb === 1'b1);
        c_de += (de === 1'b1);
      end
    end
    run = 1'b0;
    if (k < n) begin
      n_mismatch++;
      $display("unexpected line pulses: expected %0d, seen %0d", n, k);
      wrap_up();
    end
  endtask
  task automatic t_reset();
    rd_chk(IDX_VSYNC_END_IRQ, 8'h80);
    rd_chk(IDX_CRTC_MODE, 8'h00);
    rd_chk(8'h40, 8'h00);
    cmp("refresh cycles", 8'h03, {5'h00, refc});
    $display("reset test done");
  endtask
  task automatic t_lock();
    wr(IDX_VERT_TOTAL_LOW, 8'h12);
    rd_chk(IDX_VERT_TOTAL_LOW, 8'h00);
    wr(IDX_OVERFLOW, 8'hFF);
    rd_chk(IDX_OVERFLOW, 8'h10);
    wr(IDX_VSYNC_END_IRQ, 8'h00);
    wr(IDX_VERT_TOTAL_LOW, 8'h12);
    rd_chk(IDX_VERT_TOTAL_LOW, 8'h12);
    $display("lock test done");
  endtask
  task automatic t_refresh();
    logic [2:0] exp [4] = '{3'h5, 3'h1, 3'h2, 3'h4};
    wr(IDX_VSYNC_END_IRQ, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_REFRESH_OVERRIDE, 8'(i));
      repeat (3) @(negedge clk);
      cmp("refresh cycles", {5'h00, exp[i]}, {5'h00, refc});
    end
    wr(IDX_REFRESH_OVERRIDE, 8'h00);
    $display("refresh test done");
  endtask
  task automatic t_frame();
    wr(IDX_OVERFLOW, 8'h00);
    wr(IDX_VSYNC_START_LOW, 8'h05);
    wr(IDX_VSYNC_END_IRQ, 8'h18);
    wr(IDX_DISPLAY_END_LOW, 8'h03);
    wr(IDX_VBLANK_START_LOW, 8'h09);
    wr(IDX_VBLANK_END, 8'h0E);
    wr(IDX_GLOBAL_IRQ_EN, 8'h10);
    wr(IDX_CRTC_MODE, 8'h80);
    lines(40);
    cmp("sync lines", 8'd6, 8'(c_vs));
    cmp("blank lines", 8'd8, 8'(c_vb));
    cmp("display lines", 8'd8, 8'(c_de));
    cmp("hsync seen", 8'h01, 8'(c_hs > 0));
    cmp("interrupt", 8'h01, {7'h00, irq});
    wr(IDX_VSYNC_END_IRQ, 8'h38);
    wait_irq(1'b0);
    wr(IDX_VSYNC_END_IRQ, 8'h18);
    wait_irq(1'b1);
    wr(IDX_GLOBAL_IRQ_EN, 8'h00);
    wait_irq(1'b0);
    wr(IDX_GLOBAL_IRQ_EN, 8'h10);
    wr(IDX_VSYNC_END_IRQ, 8'h08);
    wait_irq(1'b0);
    wr(IDX_VSYNC_END_IRQ, 8'h18);
    wait_irq(1'b0);
    lines(40);
    cmp("interrupt", 8'h01, {7'h00, irq});
    $display("frame test done");
  endtask
  task automatic t_halve();
    wr(IDX_CRTC_MODE, 8'h84);
    lines(80);
    cmp("sync pulses", 8'd12, 8'(c_vs));
    cmp("blank pulses", 8'd16, 8'(c_vb));
    wr(IDX_CRTC_MODE, 8'h04);
    lines(80);
    cmp("sync pulses", 8'd0, 8'(c_vs));
    cmp("hsync cycles", 8'd0, 8'(c_hs));
    cmp("blank pulses", 8'd16, 8'(c_vb));
    $display("halve test done");
  endtask
  task automatic addr_chk(input logic [7:0] idx, input logic [7:0] d, input logic [15:0] exp);
    wr(idx, d);
    repeat (2) @(negedge clk);
    cmp16("memory address", exp, maddr);
  endtask
  // Start address only loads at the frame wrap, so one whole frame runs before rows count
  task automatic t_addr();
    @(negedge clk);
    sa = 16'hC001;
    wr(IDX_CRTC_MODE, 8'h43);
    wr(IDX_MAX_SCAN_LINE, 8'h01);
    wr(IDX_ROW_PITCH_LOW, 8'h10);
    lines(23);
    repeat (2) @(negedge clk);
    cmp16("memory address", 16'hC021, maddr);
    cmp("row scan", 8'h01, {3'h0, rscan});
    cmp("underline", 8'h01, {7'h00, ul});
    addr_chk(IDX_CRTC_MODE, 8'h42, 16'hE021);
    addr_chk(IDX_CRTC_MODE, 8'h41, 16'h8021);
    addr_chk(IDX_CRTC_MODE, 8'h03, 16'h8042);
    addr_chk(IDX_CRTC_MODE, 8'h23, 16'h8043);
    addr_chk(IDX_UNDERLINE_DWORD, 8'h40, 16'h0087);
    wr(IDX_UNDERLINE_DWORD, 8'h00);
    wr(IDX_FORCE_DWORD, 8'h08);
    wr(IDX_CRTC_MODE, 8'h43);
    lines(2);
    repeat (2) @(negedge clk);
    cmp16("memory address", 16'hC061, maddr);
    $display("address test done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_lock();
    t_refresh();
    t_frame();
    t_halve();
    t_addr();
    wrap_up();
  end
endmodule
